// ==== logic/asa_regs.svh ====
// Purpose: register selects, field positions, reset values and counts
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef ASA_REGS_SVH
`define ASA_REGS_SVH
`define ASA_CLK_PERIOD_NS 4
`define ASA_REF_HZ 1843200
`define ASA_SEL_DATA 2'h0
`define ASA_SEL_STATUS 2'h1
`define ASA_SEL_CMD 2'h2
`define ASA_SEL_CTL 2'h3
`define ASA_CMD_RESET 8'h00
`define ASA_CTL_RESET 8'h00
`define ASA_CMD_SOFT_KEEP 8'hE0
`define ASA_CMD_DTR 0
`define ASA_CMD_IRQ_OFF 1
`define ASA_CMD_RTS_LO 2
`define ASA_CMD_RTS_HI 3
`define ASA_CTL_RATE_LO 0
`define ASA_CTL_RATE_HI 3
`define ASA_CTL_RX_INT 4
`define ASA_ST_FRM 1
`define ASA_ST_OVR 2
`define ASA_RATE_EXT 4'h0
`define ASA_TICK_LAST 4'hF
`define ASA_TICK_MID 4'h7
`define ASA_BIT_LAST 3'h7
`define ASA_SYNC_W 21
`define ASA_SYNC_RST 21'h07C000
`endif

// ==== logic/asa_pkg.sv ====
// Purpose: state types of the serial adapter
// Assumes: nothing
// Notes: one-hot codes written out
package asa_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } asa_tx_state_type;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } asa_rx_state_type;
endpackage

// ==== logic/asa_buf2.sv ====
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: a full buffer drops in_ready; clear empties it
`timescale 1ns/1ps
`default_nettype none
module asa_buf2 (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    logic [7:0] ent0_r, ent1_r, ent0_nxt, ent1_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = rd_r ? ent1_r : ent0_r;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers and count; push and pop may share a cycle
    always_comb begin
        ent0_nxt = ent0_r;
        ent1_nxt = ent1_r;
        rd_nxt = rd_r ^ pop;
        wr_nxt = wr_r ^ push;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
        if (push && !wr_r) begin
            ent0_nxt = in_data;
        end
        if (push && wr_r) begin
            ent1_nxt = in_data;
        end
        if (clear) begin
            rd_nxt = 1'b0;
            wr_nxt = 1'b0;
            cnt_nxt = 2'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ent0_r <= 8'h00;
            ent1_r <= 8'h00;
            cnt_r <= 2'h0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            ent0_r <= ent0_nxt;
            ent1_r <= ent1_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== logic/asa_top.sv ====
// Purpose: host register decode and modem-side serial engine of the adapter
// Assumes: every pin input is asynchronous to clock and passes two flops
// Notes: 8 data bits, 1 stop bit, no parity; bus cycle ends on phase fall
// Behaviour
// - two selects pick data, reset/status, command or control register.
// - only command and control read back; data reads receive, writes transmit; status read-only.
// - select-1 write ignores data, clears command bits 0-4, status bit 2.
// - transmitter sends holding byte least significant bit first.
// - transmit rate from programmed divider or external clock per control.
// - receiver assembles incoming byte least significant bit first.
// - receive rate is the programmed rate or the external receive clock.
// - receive clock pin inputs 16x clock, or outputs it when internal.
// - request-to-send output follows the command register only.
// - transmitter runs only while clear-to-send is low.
// - terminal-ready output is low when command bit 0 is set.
// - data-set-ready low means modem ready.
// - carrier-detect low means carrier present.
// - external clocking gives one bit per sixteen clock periods.
// - programmed rates derive from the crystal reference input.
// - adapter selected only with high select high, low select low.
// - read/write high reads; data bus driven only in selected reads.
// - interrupt line idles released and pulls low on interrupt.
// - hardware reset pin low clears command, control, status flags and transmit buffer; receive holding keeps its value.
`timescale 1ns/1ps
`default_nettype none
`include "asa_regs.svh"
module asa_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bus_phase_clock,
    input wire logic select_active_high,
    input wire logic select_active_low,
    input wire logic read_not_write,
    input wire logic reg_select_lo,
    input wire logic reg_select_hi,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic irq_out,
    output logic irq_oe,
    input wire logic hardware_reset_n,
    input wire logic crystal_in,
    input wire logic receive_16x_clock_pin_in,
    output logic receive_16x_clock_pin_out,
    output logic receive_16x_clock_pin_oe,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic dcd_n,
    output logic rts_n,
    output logic dtr_n
);
    logic [`ASA_SYNC_W-1:0] meta_r, sync_r, pins;
    logic q2_s, sel, rw_s, hw_rst, rxd_s, cts_s, dsr_s, dcd_s, xtal_s, rxc_s;
    logic [1:0] rs;
    logic [7:0] data_s;
    logic q2_d_r, xtal_d_r, rxc_d_r, rxd_d_r;
    logic q2_fall, wr_stb, rd_end, rx_tick, tx_en, tx_pop;
    logic buf_in_ready, buf_valid;
    logic [7:0] buf_data;
    logic [7:0] cmd_r, cmd_nxt, ctl_r, ctl_nxt, hold_r, hold_nxt, dout_r, dout_nxt;
    logic full_r, full_nxt, ovr_r, ovr_nxt, frm_r, frm_nxt, doe_r, doe_nxt;
    logic [3:0] div_r, div_nxt, rate;
    logic tick_r, tick_nxt, rxco_r, rxco_nxt, rxcoe_r, rxcoe_nxt;
    asa_pkg::asa_tx_state_type tx_st_r, tx_st_nxt;
    asa_pkg::asa_rx_state_type rx_st_r, rx_st_nxt;
    logic [3:0] tx_tc_r, tx_tc_nxt, rx_tc_r, rx_tc_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
    logic txd_r, txd_nxt, done_r, done_nxt, rfrm_r, rfrm_nxt;
    logic rts_r, rts_nxt, dtr_r, dtr_nxt, irq_r, irq_nxt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // last count of the reference divider for a rate code
    function automatic logic [3:0] rate_top(input logic [3:0] code);
        rate_top = (code == `ASA_RATE_EXT) ? 4'h0 : ~code;
    endfunction

    // two-flop synchronisers; only sync_r is read by logic
    assign pins = {receive_16x_clock_pin_in, crystal_in, dcd_n, dsr_n, cts_n, rxd,
                   hardware_reset_n, data_in, reg_select_hi, reg_select_lo,
                   read_not_write, select_active_low, select_active_high,
                   bus_phase_clock};
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= `ASA_SYNC_RST;
            sync_r <= `ASA_SYNC_RST;
            q2_d_r <= 1'b0;
            xtal_d_r <= 1'b0;
            rxc_d_r <= 1'b0;
            rxd_d_r <= 1'b1;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            q2_d_r <= q2_s;
            xtal_d_r <= xtal_s;
            rxc_d_r <= rxc_s;
            rxd_d_r <= rxd_s;
        end
    end

    assign q2_s = sync_r[0];
    assign sel = sync_r[1] & ~sync_r[2];
    assign rw_s = sync_r[3];
    assign rs = sync_r[5:4];
    assign data_s = sync_r[13:6];
    assign hw_rst = ~sync_r[14];
    assign rxd_s = sync_r[15];
    assign cts_s = sync_r[16];
    assign dsr_s = sync_r[17];
    assign dcd_s = sync_r[18];
    assign xtal_s = sync_r[19];
    assign rxc_s = sync_r[20];

    // a bus cycle ends on the falling phase edge; both strobes act there
    assign q2_fall = q2_d_r & ~q2_s;
    assign wr_stb = q2_fall & sel & ~rw_s;
    assign rd_end = q2_fall & sel & rw_s;

    // register file; new received word beats a same-cycle read clear
    always_comb begin
        cmd_nxt = cmd_r;
        ctl_nxt = ctl_r;
        hold_nxt = hold_r;
        full_nxt = full_r;
        ovr_nxt = ovr_r;
        frm_nxt = frm_r;
        if (wr_stb) begin
            unique case (rs)
                `ASA_SEL_DATA: begin
                    cmd_nxt = cmd_r;
                end
                `ASA_SEL_STATUS: begin
                    cmd_nxt = cmd_r & `ASA_CMD_SOFT_KEEP;
                    ovr_nxt = 1'b0;
                end
                `ASA_SEL_CMD: begin
                    cmd_nxt = data_s;
                end
                `ASA_SEL_CTL: begin
                    ctl_nxt = data_s;
                end
            endcase
        end
        if (rd_end && rs == `ASA_SEL_DATA) begin
            full_nxt = 1'b0;
        end
        if (done_r) begin
            if (full_r && !(rd_end && rs == `ASA_SEL_DATA)) begin
                ovr_nxt = 1'b1;
            end else begin
                hold_nxt = rx_sh_r;
                full_nxt = 1'b1;
                frm_nxt = rfrm_r;
            end
        end
        if (hw_rst) begin
            cmd_nxt = `ASA_CMD_RESET;
            ctl_nxt = `ASA_CTL_RESET;
            full_nxt = 1'b0;
            ovr_nxt = 1'b0;
            frm_nxt = 1'b0;
        end
        doe_nxt = q2_s & sel & rw_s;
        unique case (rs)
            `ASA_SEL_DATA: dout_nxt = hold_r;
            `ASA_SEL_STATUS: dout_nxt = {irq_r, dsr_s, dcd_s, buf_in_ready,
                                         full_r, ovr_r, frm_r, 1'b0};
            `ASA_SEL_CMD: dout_nxt = cmd_r;
            `ASA_SEL_CTL: dout_nxt = ctl_r;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r <= `ASA_CMD_RESET;
            ctl_r <= `ASA_CTL_RESET;
            hold_r <= 8'h00;
            full_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            dout_r <= 8'h00;
            doe_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            ctl_r <= ctl_nxt;
            hold_r <= hold_nxt;
            full_r <= full_nxt;
            ovr_r <= ovr_nxt;
            frm_r <= frm_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
        end
    end

    // transmit bytes wait here; a full buffer refuses further data writes
    asa_buf2 u_txbuf (
        .clock(clock),
        .reset_n(reset_n),
        .clear(hw_rst),
        .in_valid(wr_stb && rs == `ASA_SEL_DATA),
        .in_ready(buf_in_ready),
        .in_data(data_s),
        .out_valid(buf_valid),
        .out_ready(tx_pop),
        .out_data(buf_data)
    );

    // 16x tick from crystal rising edges; code 0 takes each rising edge as the tick
    assign rate = ctl_r[`ASA_CTL_RATE_HI:`ASA_CTL_RATE_LO];
    always_comb begin
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (xtal_s && !xtal_d_r) begin
            if (div_r >= rate_top(rate)) begin
                div_nxt = 4'h0;
                tick_nxt = 1'b1;
            end else begin
                div_nxt = div_r + 4'h1;
            end
        end
        // the pin copies the reference when the divider passes every edge
        rxco_nxt = (rate_top(rate) == 4'h0) ? xtal_d_r : (div_r <= (rate_top(rate) >> 1));
        rxcoe_nxt = ctl_r[`ASA_CTL_RX_INT];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 4'h0;
            tick_r <= 1'b0;
            rxco_r <= 1'b0;
            rxcoe_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            rxco_r <= rxco_nxt;
            rxcoe_r <= rxcoe_nxt;
        end
    end

    assign rx_tick = ctl_r[`ASA_CTL_RX_INT] ? tick_r : (rxc_s & ~rxc_d_r);

    // transmitter; dropping clear-to-send abandons the character
    assign tx_en = cmd_r[`ASA_CMD_DTR] & ~cts_s;
    assign tx_pop = (tx_st_r == asa_pkg::TX_IDLE) & tx_en & ~hw_rst;
    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_tc_nxt = tx_tc_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        unique case (tx_st_r)
            asa_pkg::TX_IDLE: begin
                if (tx_pop && buf_valid) begin
                    tx_st_nxt = asa_pkg::TX_START;
                    tx_sh_nxt = buf_data;
                    tx_tc_nxt = 4'h0;
                end
            end
            asa_pkg::TX_START: begin
                if (tick_r) begin
                    tx_tc_nxt = tx_tc_r + 4'h1;
                    if (tx_tc_r == `ASA_TICK_LAST) begin
                        tx_st_nxt = asa_pkg::TX_DATA;
                        tx_bit_nxt = 3'h0;
                    end
                end
            end
            asa_pkg::TX_DATA: begin
                if (tick_r) begin
                    tx_tc_nxt = tx_tc_r + 4'h1;
                    if (tx_tc_r == `ASA_TICK_LAST) begin
                        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                        tx_bit_nxt = tx_bit_r + 3'h1;
                        if (tx_bit_r == `ASA_BIT_LAST) begin
                            tx_st_nxt = asa_pkg::TX_STOP;
                        end
                    end
                end
            end
            asa_pkg::TX_STOP: begin
                if (tick_r) begin
                    tx_tc_nxt = tx_tc_r + 4'h1;
                    if (tx_tc_r == `ASA_TICK_LAST) begin
                        tx_st_nxt = asa_pkg::TX_IDLE;
                    end
                end
            end
        endcase
        if (!tx_en || hw_rst) begin
            tx_st_nxt = asa_pkg::TX_IDLE;
        end
        // line level follows the next state so it never lags a tick
        if (tx_st_nxt == asa_pkg::TX_START) begin
            txd_nxt = 1'b0;
        end else if (tx_st_nxt == asa_pkg::TX_DATA) begin
            txd_nxt = tx_sh_nxt[0];
        end else begin
            txd_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r <= asa_pkg::TX_IDLE;
            tx_tc_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            txd_r <= 1'b1;
        end else begin
            tx_st_r <= tx_st_nxt;
            tx_tc_r <= tx_tc_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
            txd_r <= txd_nxt;
        end
    end

    // receiver; start edge checked at mid-bit, then one sample per 16 ticks
    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_tc_nxt = rx_tc_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        done_nxt = 1'b0;
        rfrm_nxt = rfrm_r;
        unique case (rx_st_r)
            asa_pkg::RX_IDLE: begin
                if (rxd_d_r && !rxd_s) begin
                    rx_st_nxt = asa_pkg::RX_START;
                    rx_tc_nxt = 4'h0;
                end
            end
            asa_pkg::RX_START: begin
                if (rx_tick) begin
                    rx_tc_nxt = rx_tc_r + 4'h1;
                    if (rx_tc_r == `ASA_TICK_MID) begin
                        rx_st_nxt = rxd_s ? asa_pkg::RX_IDLE : asa_pkg::RX_DATA;
                        rx_tc_nxt = 4'h0;
                        rx_bit_nxt = 3'h0;
                    end
                end
            end
            asa_pkg::RX_DATA: begin
                if (rx_tick) begin
                    rx_tc_nxt = rx_tc_r + 4'h1;
                    if (rx_tc_r == `ASA_TICK_LAST) begin
                        rx_sh_nxt = {rxd_s, rx_sh_r[7:1]};
                        rx_bit_nxt = rx_bit_r + 3'h1;
                        if (rx_bit_r == `ASA_BIT_LAST) begin
                            rx_st_nxt = asa_pkg::RX_STOP;
                        end
                    end
                end
            end
            asa_pkg::RX_STOP: begin
                if (rx_tick) begin
                    rx_tc_nxt = rx_tc_r + 4'h1;
                    if (rx_tc_r == `ASA_TICK_LAST) begin
                        rx_st_nxt = asa_pkg::RX_IDLE;
                        done_nxt = 1'b1;
                        rfrm_nxt = ~rxd_s;
                    end
                end
            end
        endcase
        if (hw_rst) begin
            rx_st_nxt = asa_pkg::RX_IDLE;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_r <= asa_pkg::RX_IDLE;
            rx_tc_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            done_r <= 1'b0;
            rfrm_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            rx_tc_r <= rx_tc_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            done_r <= done_nxt;
            rfrm_r <= rfrm_nxt;
        end
    end

    // modem handshake lines and the shared interrupt line
    always_comb begin
        rts_nxt = ~(cmd_r[`ASA_CMD_RTS_HI] | cmd_r[`ASA_CMD_RTS_LO]);
        dtr_nxt = ~cmd_r[`ASA_CMD_DTR];
        irq_nxt = full_r & ~cmd_r[`ASA_CMD_IRQ_OFF];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rts_r <= 1'b1;
            dtr_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            rts_r <= rts_nxt;
            dtr_r <= dtr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign data_out = dout_r;
    assign data_oe = doe_r;
    assign irq_out = 1'b0; // open drain: only the enable moves
    assign irq_oe = irq_r;
    assign receive_16x_clock_pin_out = rxco_r;
    assign receive_16x_clock_pin_oe = rxcoe_r;
    assign txd = txd_r;
    assign rts_n = rts_r;
    assign dtr_n = dtr_r;

    sequence s_cmd_write;
        wr_stb && rs == `ASA_SEL_CMD && !hw_rst;
    endsequence
    sequence s_soft_reset;
        wr_stb && rs == `ASA_SEL_STATUS && !hw_rst;
    endsequence
    sequence s_tx_bit_end;
        tick_r && tx_st_r == asa_pkg::TX_DATA && tx_tc_r == `ASA_TICK_LAST && tx_en;
    endsequence

    a_cmd_write: assert property (s_cmd_write |=> cmd_r == $past(data_s))
        else $error("command write not stored");
    a_ro_ignore: assert property (wr_stb && rs == `ASA_SEL_DATA && !done_r |=>
        $stable(hold_r))
        else $error("receive holding changed by a write");
    a_soft_clear: assert property (s_soft_reset |=> cmd_r[4:0] == 5'h00 &&
        cmd_r[7:5] == $past(cmd_r[7:5]))
        else $error("programmed reset command effect wrong");
    a_soft_ovr: assert property (s_soft_reset ##0 !done_r |=> !ovr_r)
        else $error("programmed reset left overrun set");
    a_tx_lsb: assert property ($rose(tx_st_r == asa_pkg::TX_DATA) |->
        txd_r == tx_sh_r[0] && tx_bit_r == 3'h0)
        else $error("first data bit is not bit 0");
    a_bit_time: assert property (s_tx_bit_end ##0 !hw_rst |=>
        tx_sh_r == {1'b0, $past(tx_sh_r[7:1])})
        else $error("bit did not end after sixteen ticks");
    a_xtal_ref: assert property (tick_r |-> $past(xtal_s && !xtal_d_r))
        else $error("tick without reference edge");
    a_rx_lsb: assert property (rx_tick && rx_st_r == asa_pkg::RX_DATA &&
        rx_tc_r == `ASA_TICK_LAST && !hw_rst |=> rx_sh_r[7] == $past(rxd_s))
        else $error("receive sample misplaced");
    a_rx_src: assert property (!ctl_r[`ASA_CTL_RX_INT] && !(rxc_s && !rxc_d_r) |->
        !rx_tick)
        else $error("receive tick from wrong source");
    a_rxc_dir: assert property (1'b1 |=> rxcoe_r == $past(ctl_r[`ASA_CTL_RX_INT]))
        else $error("receive clock pin direction wrong");
    a_rts_cmd: assert property (1'b1 |=> rts_n == !$past(cmd_r[3] || cmd_r[2]))
        else $error("request-to-send not from command");
    a_cts_stop: assert property (cts_s |=> tx_st_r == asa_pkg::TX_IDLE ##0 txd_r)
        else $error("transmitter ran with clear-to-send high");
    a_dtr_cmd: assert property ($changed(cmd_r[0]) |=> dtr_n == !$past(cmd_r[0]))
        else $error("terminal-ready wrong");
    a_modem_st: assert property (q2_s && sel && rw_s && rs == `ASA_SEL_STATUS |=>
        dout_r[6] == $past(dsr_s) && dout_r[5] == $past(dcd_s))
        else $error("modem status bits wrong");
    a_read_drive: assert property (data_oe |-> $past(q2_s && sel && rw_s))
        else $error("data bus driven outside a read");
    a_irq_level: assert property (1'b1 |=> irq_oe == $past(full_r && !cmd_r[1]))
        else $error("interrupt line wrong");
    a_hw_reset: assert property (hw_rst |=> cmd_r == `ASA_CMD_RESET &&
        ctl_r == `ASA_CTL_RESET && !full_r)
        else $error("hardware reset did not clear");
    a_idle_mark: assert property (tx_st_r == asa_pkg::TX_IDLE |-> txd_r)
        else $error("idle line not at mark");
endmodule
`default_nettype wire

// ==== test/asa_modem.sv ====
// Purpose: modem side model, 16x clock source and serial sender
// Assumes: the reference runs free like a crystal
// Notes: frames are 8N1, low bit first
`timescale 1ns/1ps
`default_nettype none
module asa_modem (
    output logic clk16,
    output logic rxd
);
    // free running 16x reference, period twelve system clocks, edges on its falling edges
    initial clk16 = 1'b0;
    always #24 clk16 = ~clk16;
    initial rxd = 1'b1;
    // one frame: start, eight data bits, stop; line rests at mark after
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (16) @(posedge clk16);
        end
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: register and serial checks of the adapter top
// Assumes: 16x clock shared by crystal and receive clock pins
// Notes: bus cycles last 12 clocks, phase falls mid-cycle
`timescale 1ns/1ps
`default_nettype none
`include "asa_regs.svh"
module tb_top;
    logic clock = 1'b0, reset_n = 1'b0, phase = 1'b0, cs_hi = 1'b0, cs_lo = 1'b1;
    logic rnw = 1'b1, hw_n = 1'b1, cts_n = 1'b0, dsr_n = 1'b1, dcd_n = 1'b1;
    logic [1:0] rs = 2'h0;
    logic [7:0] din = 8'h00, dout, rd;
    logic doe, txd, rts_n, dtr_n, rxc_oe, clk16, rxd, irq_q, irq_oe, rxc_q;
    logic [9:0] f;
    int failures = 0;
    int cmp_count = 0;
    always #2 clock = ~clock;
    asa_modem u_mdm (.clk16(clk16), .rxd(rxd));
    asa_top u_dut (.clock(clock), .reset_n(reset_n), .bus_phase_clock(phase),
        .select_active_high(cs_hi), .select_active_low(cs_lo), .read_not_write(rnw),
        .reg_select_lo(rs[0]), .reg_select_hi(rs[1]), .data_in(din), .data_out(dout),
        .data_oe(doe), .irq_out(irq_q), .irq_oe(irq_oe), .hardware_reset_n(hw_n),
        .crystal_in(clk16), .receive_16x_clock_pin_in(clk16),
        .receive_16x_clock_pin_out(rxc_q),
        .receive_16x_clock_pin_oe(rxc_oe), .rxd(rxd), .txd(txd), .cts_n(cts_n),
        .dsr_n(dsr_n), .dcd_n(dcd_n), .rts_n(rts_n), .dtr_n(dtr_n));
    task automatic print_verdict();
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle; read data taken only while the adapter drives the bus
    task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d,
            input logic sel);
        @(negedge clock);
        phase = 1'b1;
        cs_hi = sel;
        cs_lo = 1'b0;
        rnw = r;
        rs = s;
        din = d;
        repeat (6) @(negedge clock);
        rd = doe ? dout : 8'hXX;
        phase = 1'b0;
        repeat (6) @(negedge clock);
        cs_hi = 1'b0;
        cs_lo = 1'b1;
    endtask
    // bounded wait for a level on the transmit line
    task automatic wait_txd(input logic v);
        int n;
        n = 0;
        while (txd !== v && n < 4000) begin
            @(negedge clock);
            n++;
        end
        if (n == 4000) begin
            failures++;
            $display("MISMATCH t=%0t transmit line stuck", $time);
            print_verdict();
        end
    endtask
    initial begin
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        repeat (8) @(negedge clock);
        check({7'h00, txd}, 8'h01);
        acc(1'b1, `ASA_SEL_CMD, 8'h00, 1'b1);
        check(rd, `ASA_CMD_RESET);
        acc(1'b0, `ASA_SEL_CMD, 8'hE5, 1'b1);
        acc(1'b1, `ASA_SEL_CMD, 8'h00, 1'b1);
        check(rd, 8'hE5);
        check({6'h00, rts_n, dtr_n}, 8'h00);
        acc(1'b0, `ASA_SEL_CTL, 8'hB0, 1'b1);
        check({7'h00, rxc_oe}, 8'h01);
        // driven 16x clock follows the reference, so it flips every half period
        rd[0] = rxc_q;
        repeat (6) @(negedge clock);
        check({7'h00, rxc_q ^ rd[0]}, 8'h01);
        acc(1'b0, `ASA_SEL_CTL, 8'hA0, 1'b1);
        acc(1'b1, `ASA_SEL_CTL, 8'h00, 1'b1);
        check({rd[7:1], rxc_oe}, 8'hA0);
        u_mdm.send(8'h3C);
        u_mdm.send(8'h5A);
        repeat (300) @(negedge clock);
        acc(1'b1, `ASA_SEL_STATUS, 8'h00, 1'b1);
        check({6'h00, rd[3:2]}, 8'h03);
        check({6'h00, irq_q, irq_oe}, 8'h01);
        acc(1'b1, `ASA_SEL_DATA, 8'h00, 1'b1);
        check(rd, 8'h3C);
        check({7'h00, irq_oe}, 8'h00);
        acc(1'b0, `ASA_SEL_STATUS, 8'hFF, 1'b1);
        acc(1'b1, `ASA_SEL_CMD, 8'h00, 1'b1);
        check(rd, 8'hE0);
        check({7'h00, dtr_n}, 8'h01);
        acc(1'b1, `ASA_SEL_CTL, 8'h00, 1'b1);
        check(rd, 8'hA0);
        dsr_n = 1'b0;
        acc(1'b1, `ASA_SEL_STATUS, 8'h00, 1'b1);
        check({5'h00, rd[6:5], rd[2]}, 8'h02);
        acc(1'b0, `ASA_SEL_CMD, 8'h01, 1'b0);
        acc(1'b1, `ASA_SEL_CMD, 8'h00, 1'b1);
        check(rd, 8'hE0);
        acc(1'b0, `ASA_SEL_CMD, 8'h01, 1'b1);
        acc(1'b0, `ASA_SEL_DATA, 8'hA5, 1'b1);
        wait_txd(1'b0);
        f = {1'b1, 8'hA5, 1'b0};
        repeat (96) @(negedge clock);
        // mid-bit samples, sixteen 48 ns ticks per bit
        for (int i = 0; i < 10; i++) begin
            check({7'h00, txd}, {7'h00, f[i]});
            repeat (192) @(negedge clock);
        end
        cts_n = 1'b1;
        acc(1'b0, `ASA_SEL_DATA, 8'h0F, 1'b1);
        for (int i = 0; i < 400; i++) begin
            @(negedge clock);
            check({7'h00, txd}, 8'h01);
        end
        cts_n = 1'b0;
        wait_txd(1'b0);
        hw_n = 1'b0;
        repeat (5) @(negedge clock);
        hw_n = 1'b1;
        acc(1'b1, `ASA_SEL_CMD, 8'h00, 1'b1);
        check(rd, `ASA_CMD_RESET);
        print_verdict();
    end
endmodule
`default_nettype wire
